/* File: csd_chan_if.sv */
// request and readback signals between register file and one channel
`timescale 1ns/10ps
interface csd_chan_if;
    logic [3:0] req_sel;
    logic [4:0] req_div;
    logic [3:0] cur_sel;
    logic [4:0] cur_div;
    modport ctrl (output req_sel, output req_div,
                  input cur_sel, input cur_div);
    modport chan (input req_sel, input req_div,
                  output cur_sel, output cur_div);
endinterface

/* File: csd_clk_chan.sv */
// one output clock: pll divider and glitch-free source switch
`timescale 1ns/10ps
module csd_clk_chan #(
    parameter logic [3:0] RST_SEL = 4'h2,
    parameter logic [4:0] RST_DIV = 5'h00
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic reference_clock_in,
    input wire logic system_pll_clock_in,
    csd_chan_if.chan cfg,
    output logic clk_out
);
    csd_pkg::csd_chan_st_t st;
    csd_pkg::csd_chan_st_t next_st;
    logic rise;
    logic boundary;
    logic [5:0] half;
    logic [4:0] cnt_inc;
    logic old_lvl;
    logic new_lvl;
    logic req_ok;

    always_comb
    begin
        next_st = st;
        rise = system_pll_clock_in & ~st.pll_q;
        boundary = rise && (st.cnt == st.cur_div);
        half = ({1'b0, st.cur_div} + 6'h02) >> 1;
        cnt_inc = st.cnt + 5'h01;
        next_st.pll_q = system_pll_clock_in;
        if (boundary)
        begin
            // new divisor only at a period edge, so no runt pulse
            next_st.cnt = 5'h00;
            next_st.cur_div = cfg.req_div;
            next_st.div_clk = 1'b1;
        end
        else if (rise)
        begin
            next_st.cnt = cnt_inc;
            next_st.div_clk = {1'b0, cnt_inc} < half;
        end
        else if (st.cur_div == 5'h00)
        begin
            next_st.div_clk = system_pll_clock_in;
        end
        old_lvl = (st.cur_sel == csd_pkg::SEL_REF) ?
            reference_clock_in : st.div_clk;
        new_lvl = (cfg.req_sel == csd_pkg::SEL_REF) ?
            reference_clock_in : st.div_clk;
        // illegal select codes are ignored, old source kept
        req_ok = (cfg.req_sel == csd_pkg::SEL_REF) ||
            (cfg.req_sel == csd_pkg::SEL_PLL);
        if (req_ok && cfg.req_sel != st.cur_sel && !st.clk_out &&
            !old_lvl && !new_lvl)
        begin
            next_st.cur_sel = cfg.req_sel;
        end
        next_st.clk_out = (st.cur_sel == csd_pkg::SEL_REF) ?
            reference_clock_in : st.div_clk;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st <= '{pll_q: 1'b0, cnt: 5'h00, div_clk: 1'b0,
                    cur_sel: RST_SEL, cur_div: RST_DIV,
                    clk_out: 1'b0};
        end
        else if (ce_in)
        begin
            st <= next_st;
        end
    end

    assign clk_out = st.clk_out;
    assign cfg.cur_sel = st.cur_sel;
    assign cfg.cur_div = st.cur_div;

    a_pll_path_out: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && st.cur_sel == csd_pkg::SEL_PLL
        |=> clk_out == $past(st.div_clk))
        else $error("divided pll not on output");
    a_period_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && boundary |=> st.cnt == 5'h00 && st.div_clk)
        else $error("divider period did not restart");
    a_src_legal: assert property (@(posedge clk_in) disable iff (rst_in)
        st.cur_sel == csd_pkg::SEL_REF || st.cur_sel == csd_pkg::SEL_PLL)
        else $error("illegal source in effect");
    a_div_at_edge: assert property (@(posedge clk_in) disable iff (rst_in)
        $changed(st.cur_div) |-> $past(boundary))
        else $error("divisor changed mid period");
    a_sel_when_low: assert property (@(posedge clk_in) disable iff (rst_in)
        $changed(st.cur_sel) |-> $past(clk_out) == 1'b0 && clk_out == 1'b0)
        else $error("source switched while output high");
    c_src_switch: cover property (@(posedge clk_in) disable iff (rst_in)
        $changed(st.cur_sel));
    c_div_change: cover property (@(posedge clk_in) disable iff (rst_in)
        $changed(st.cur_div));
endmodule

/* File: csd_clock_ctrl.sv */
// register file on avalon-mm and the four controlled output clocks
`timescale 1ns/10ps
// Functional notes
// - selected divided pll drives the output
// - divisor field bits 4:0, ratio value plus one
// - bits 20:16 read back divisor in effect
// - divider writes touch bits 4:0 only
// - test-stream divider resets to 0x13
// - interconnect divider resets to 0x07
// - i2c divider resets to zero
// - quad-spi divider resets to zero
// - select bits 3:0, 1 reference, 2 pll
// - bits 11:8 read back source in effect
// - source writes touch bits 3:0 only
// - interconnect resets to pll, i2c to reference
// - quad-spi select resets to reference
// - i2c select accepts writes
module csd_clock_ctrl (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic reference_clock_in,
    input wire logic system_pll_clock_in,
    output logic test_stream_double_rate_clock_out,
    output logic control_processor_interconnect_clock_out,
    output logic control_processor_i2c_clock_out,
    output logic control_processor_quadspi_clock_out
);
    localparam int N = csd_pkg::NUM_CH;

    csd_pkg::csd_regs_st_t st;
    csd_pkg::csd_regs_st_t next_st;
    logic [N-1:0][3:0] cur_sel_w;
    logic [N-1:0][4:0] cur_div_w;
    logic [N-1:0] clk_w;
    logic req;
    logic [31:0] rd;

    assign req = avs_read_in | avs_write_in;
    // one wait cycle: read data is registered before the answer;
    // a frozen block keeps stalling, else a write would be lost
    assign avs_waitrequest_out = req & ~(st.ack & ce_in);
    assign avs_readdata_out = st.rdata;

    always_comb
    begin
        next_st = st;
        next_st.ack = 1'b0;
        rd = 32'h0000_0000;
        for (int i = 0; i < N; i++)
        begin
            if (avs_address_in == csd_pkg::DIV_OFF[i])
            begin
                rd[csd_pkg::DIV_LSB +: 5] = st.div[i];
                rd[csd_pkg::DIV_CUR_LSB +: 5] = cur_div_w[i];
            end
            if (i != csd_pkg::CH_TSIF &&
                avs_address_in == csd_pkg::SRC_OFF[i])
            begin
                rd[csd_pkg::SEL_LSB +: 4] = st.sel[i];
                rd[csd_pkg::SEL_CUR_LSB +: 4] = cur_sel_w[i];
            end
        end
        if (req && !st.ack)
        begin
            next_st.ack = 1'b1;
            next_st.rdata = avs_read_in ? rd : 32'h0000_0000;
        end
        // writes land on the edge where waitrequest is low
        if (avs_write_in && st.ack && avs_byteenable_in[0])
        begin
            for (int i = 0; i < N; i++)
            begin
                if (avs_address_in == csd_pkg::DIV_OFF[i])
                begin
                    next_st.div[i] =
                        avs_writedata_in[csd_pkg::DIV_LSB +: 5];
                end
                if (i != csd_pkg::CH_TSIF &&
                    avs_address_in == csd_pkg::SRC_OFF[i])
                begin
                    // i2c select kept writable like the others
                    next_st.sel[i] =
                        avs_writedata_in[csd_pkg::SEL_LSB +: 4];
                end
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st <= '{sel: csd_pkg::SEL_RST,
                    div: csd_pkg::DIV_RST,
                    ack: 1'b0,
                    rdata: 32'h0000_0000};
        end
        else if (ce_in)
        begin
            st <= next_st;
        end
    end

    generate
        for (genvar g = 0; g < N; g++)
        begin : g_chan
            csd_chan_if cif();
            assign cif.req_sel = st.sel[g];
            assign cif.req_div = st.div[g];
            assign cur_sel_w[g] = cif.cur_sel;
            assign cur_div_w[g] = cif.cur_div;
            csd_clk_chan #(
                .RST_SEL(csd_pkg::SEL_RST[g]),
                .RST_DIV(csd_pkg::DIV_RST[g])
            ) u_chan (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .ce_in(ce_in),
                .reference_clock_in(reference_clock_in),
                .system_pll_clock_in(system_pll_clock_in),
                .cfg(cif),
                .clk_out(clk_w[g])
            );
        end
    endgenerate

    assign test_stream_double_rate_clock_out = clk_w[csd_pkg::CH_TSIF];
    assign control_processor_interconnect_clock_out =
        clk_w[csd_pkg::CH_NIC];
    assign control_processor_i2c_clock_out = clk_w[csd_pkg::CH_I2C];
    assign control_processor_quadspi_clock_out = clk_w[csd_pkg::CH_QSPI];

    logic acc_done;
    assign acc_done = req && !avs_waitrequest_out && ce_in;

    a_div_write: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_done && avs_write_in && avs_byteenable_in[0] &&
        avs_address_in == csd_pkg::DIV_OFF[1]
        |=> st.div[1] == $past(avs_writedata_in[4:0]))
        else $error("divisor write not stored");
    a_div_cur_read: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_done && avs_read_in && avs_address_in == csd_pkg::DIV_OFF[2]
        |-> avs_readdata_out[20:16] == $past(cur_div_w[2]))
        else $error("divisor readback wrong");
    a_div_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_done && avs_read_in && avs_address_in == csd_pkg::DIV_OFF[0]
        |-> avs_readdata_out[15:5] == 11'h000 &&
            avs_readdata_out[31:21] == 11'h000)
        else $error("divider reserved bits not zero");
    a_tsif_reset: assert property (@(posedge clk_in)
        rst_in |=> st.div[0] == 5'h13)
        else $error("test-stream divider reset wrong");
    a_nic_div_reset: assert property (@(posedge clk_in)
        rst_in |=> st.div[1] == 5'h07)
        else $error("interconnect divider reset wrong");
    a_i2c_div_reset: assert property (@(posedge clk_in)
        rst_in |=> st.div[2] == 5'h00)
        else $error("i2c divider reset wrong");
    a_qspi_div_reset: assert property (@(posedge clk_in)
        rst_in |=> st.div[3] == 5'h00)
        else $error("quad-spi divider reset wrong");
    a_src_cur_read: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_done && avs_read_in && avs_address_in == csd_pkg::SRC_OFF[1]
        |-> avs_readdata_out[11:8] == $past(cur_sel_w[1]))
        else $error("source readback wrong");
    a_src_reserved: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_done && avs_read_in && avs_address_in == csd_pkg::SRC_OFF[3]
        |-> avs_readdata_out[7:4] == 4'h0 &&
            avs_readdata_out[31:12] == 20'h00000)
        else $error("source reserved bits not zero");
    a_sel_reset: assert property (@(posedge clk_in)
        rst_in |=> st.sel[1] == 4'h2 && st.sel[2] == 4'h1)
        else $error("select reset wrong");
    a_qspi_sel_reset: assert property (@(posedge clk_in)
        rst_in |=> st.sel[3] == 4'h1)
        else $error("quad-spi select reset wrong");
    a_i2c_sel_write: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_done && avs_write_in && avs_byteenable_in[0] &&
        avs_address_in == csd_pkg::SRC_OFF[2]
        |=> st.sel[2] == $past(avs_writedata_in[3:0]))
        else $error("i2c select write refused");
    a_wait_one: assert property (@(posedge clk_in) disable iff (rst_in)
        ce_in && req && !st.ack |=> st.ack)
        else $error("access not answered");
    a_unmapped_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        acc_done && avs_read_in && avs_address_in == 8'hFC
        |-> avs_readdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");

    c_i2c_sel_write: cover property (@(posedge clk_in) disable iff (rst_in)
        acc_done && avs_write_in && avs_address_in == csd_pkg::SRC_OFF[2]);
    c_div_read: cover property (@(posedge clk_in) disable iff (rst_in)
        acc_done && avs_read_in && avs_address_in == csd_pkg::DIV_OFF[0]);
    c_nic_to_ref: cover property (@(posedge clk_in) disable iff (rst_in)
        cur_sel_w[1] == csd_pkg::SEL_REF);
endmodule

/* File: csd_pkg.sv */
// constants and state types for the clock select and divide block
package csd_pkg;
    localparam int NUM_CH = 4;
    localparam int SEL_W = 4;
    localparam int DIV_W = 5;
    localparam int ADDR_W = 8;
    localparam int CH_TSIF = 0;
    localparam int CH_NIC = 1;
    localparam int CH_I2C = 2;
    localparam int CH_QSPI = 3;
    localparam logic [3:0] SEL_REF = 4'h1;
    localparam logic [3:0] SEL_PLL = 4'h2;
    localparam int SEL_LSB = 0;
    localparam int SEL_CUR_LSB = 8;
    localparam int DIV_LSB = 0;
    localparam int DIV_CUR_LSB = 16;
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] DIV_OFF =
        {8'h18, 8'h10, 8'h08, 8'h00};
    // the test-stream channel has no source register here
    localparam logic [NUM_CH-1:0][ADDR_W-1:0] SRC_OFF =
        {8'h14, 8'h0C, 8'h04, 8'h00};
    localparam logic [NUM_CH-1:0][DIV_W-1:0] DIV_RST =
        {5'h00, 5'h00, 5'h07, 5'h13};
    localparam logic [NUM_CH-1:0][SEL_W-1:0] SEL_RST =
        {4'h1, 4'h1, 4'h2, 4'h2};

    typedef struct packed {
        logic pll_q;
        logic [DIV_W-1:0] cnt;
        logic div_clk;
        logic [SEL_W-1:0] cur_sel;
        logic [DIV_W-1:0] cur_div;
        logic clk_out;
    } csd_chan_st_t;

    typedef struct packed {
        logic [NUM_CH-1:0][SEL_W-1:0] sel;
        logic [NUM_CH-1:0][DIV_W-1:0] div;
        logic ack;
        logic [31:0] rdata;
    } csd_regs_st_t;
endpackage

/* File: test_clock_source_select_divider.sv */
// self-checking bench for the clock select and divide register block
`timescale 1ns/10ps
module test_clock_source_select_divider;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [3:0] held;
    logic [7:0] avs_address_in = 8'h00;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0] avs_byteenable_in = 4'hF;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic reference_clock_in = 1'b0;
    logic system_pll_clock_in = 1'b0;
    logic [3:0] clks;
    int num_errors = 0;
    int cmp_count = 0;
    int tick = 0;
    int ref_cnt = 0;
    int m_sel[4];
    int m_cur[4];
    int m_div[4];
    int v;
    logic [31:0] rd;

    csd_clock_ctrl i_csd_clock_ctrl (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .reference_clock_in(reference_clock_in),
        .system_pll_clock_in(system_pll_clock_in),
        .test_stream_double_rate_clock_out(clks[0]),
        .control_processor_interconnect_clock_out(clks[1]),
        .control_processor_i2c_clock_out(clks[2]),
        .control_processor_quadspi_clock_out(clks[3])
    );

    initial
    begin
        forever #5 clk_in = ~clk_in;
    end

    // pll period 8 cycles, reference 12: both well below half the bus rate
    always @(posedge clk_in)
    begin
        tick <= tick + 1;
        system_pll_clock_in <= tick[2];
        ref_cnt <= (ref_cnt == 5) ? 0 : ref_cnt + 1;
        if (ref_cnt == 5)
            reference_clock_in <= ~reference_clock_in;
    end

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic fail_wait();
        num_errors++;
        complete_run();
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask

    // request held until a rising edge sees waitrequest low;
    // read data is taken and the request dropped at that edge
    task automatic bus(input logic wr, input logic [7:0] addr,
                       input logic [31:0] data, input logic [3:0] be);
        int k;
        @(posedge clk_in);
        avs_address_in <= addr;
        avs_writedata_in <= data;
        avs_byteenable_in <= be;
        avs_read_in <= ~wr;
        avs_write_in <= wr;
        for (k = 0; k < 50; k++)
        begin
            @(posedge clk_in);
            if (avs_waitrequest_out === 1'b0)
                break;
        end
        if (k == 50)
            fail_wait();
        rd = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    function automatic logic [31:0] dexp(input int c);
        return 32'((m_div[c] << 16) | m_div[c]);
    endfunction

    function automatic logic [31:0] sexp(input int c);
        return 32'((m_cur[c] << 8) | m_sel[c]);
    endfunction

    // readbacks only move once the output has switched cleanly
    task automatic wait_reg(input logic [7:0] addr, input logic [31:0] exp);
        int k;
        for (k = 0; k < 100; k++)
        begin
            bus(1'b0, addr, 32'h0, 4'hF);
            if (rd === exp)
                break;
        end
        check_val(rd, exp);
    endtask

    // first period skipped: it may straddle a switch
    task automatic measure(input int ch, input int per, input int hi);
        logic prev;
        int k;
        int r;
        int h;
        int p;
        prev = clks[ch];
        r = 0;
        h = 0;
        p = 0;
        for (k = 0; k < 3000 && r < 3; k++)
        begin
            @(negedge clk_in);
            if (clks[ch] === 1'b1 && prev === 1'b0)
                r++;
            if (r == 2)
            begin
                p++;
                if (clks[ch] === 1'b1)
                    h++;
            end
            prev = clks[ch];
        end
        if (r < 3)
            fail_wait();
        check_val(32'(p), 32'(per));
        check_val(32'(h), 32'(hi));
    endtask

    initial
    begin
        v = $urandom(8);
        m_div = '{19, 7, 0, 0};
        m_sel = '{2, 2, 1, 1};
        m_cur = '{2, 2, 1, 1};
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            bus(1'b0, csd_pkg::DIV_OFF[c], 32'h0, 4'hF);
            check_val(rd, dexp(c));
            if (c > 0)
            begin
                bus(1'b0, csd_pkg::SRC_OFF[c], 32'h0, 4'hF);
                check_val(rd, sexp(c));
            end
        end
        // enable low: every output clock must hold its level
        ce_in <= 1'b0;
        @(posedge clk_in);
        held = clks;
        repeat (20) @(posedge clk_in);
        check_val({28'h0, clks}, {28'h0, held});
        ce_in <= 1'b1;
        measure(csd_pkg::CH_TSIF, 160, 80);
        measure(csd_pkg::CH_NIC, 64, 32);
        measure(csd_pkg::CH_I2C, 12, 6);
        measure(csd_pkg::CH_QSPI, 12, 6);
        // unmapped place and a write without the low byte lane
        bus(1'b1, 8'hFC, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, 8'hFC, 32'h0, 4'hF);
        check_val(rd, 32'h0);
        bus(1'b1, csd_pkg::DIV_OFF[2], 32'h0000001F, 4'hE);
        bus(1'b0, csd_pkg::DIV_OFF[2], 32'h0, 4'hF);
        check_val(rd, dexp(2));
        for (int c = 0; c < 4; c++)
        begin
            v = (c == 1) ? 31 : (c == 2) ? 0 : $urandom_range(1, 30);
            m_div[c] = v;
            if (c > 0)
            begin
                m_sel[c] = 2;
                m_cur[c] = 2;
                bus(1'b1, csd_pkg::SRC_OFF[c], 32'hFFFFFFF2, 4'hF);
                wait_reg(csd_pkg::SRC_OFF[c], sexp(c));
            end
            bus(1'b1, csd_pkg::DIV_OFF[c], 32'hFFFFFFE0 | v, 4'hF);
            wait_reg(csd_pkg::DIV_OFF[c], dexp(c));
            // ratio one passes the pll through: 4 high of 8
            measure(c, (v + 1) * 8,
                (v == 0) ? 4 : ((v + 2) / 2) * 8);
        end
        m_sel[1] = 1;
        m_cur[1] = 1;
        bus(1'b1, csd_pkg::SRC_OFF[1], 32'h00000001, 4'hF);
        wait_reg(csd_pkg::SRC_OFF[1], sexp(1));
        measure(csd_pkg::CH_NIC, 12, 6);
        // an unknown code is kept but leaves the running source alone
        m_sel[1] = 5;
        bus(1'b1, csd_pkg::SRC_OFF[1], 32'h00000005, 4'hF);
        bus(1'b0, csd_pkg::SRC_OFF[1], 32'h0, 4'hF);
        check_val(rd, sexp(1));
        measure(csd_pkg::CH_NIC, 12, 6);
        complete_run();
    end
endmodule
